// ==== pkg/thermal_throttle_pkg.sv ====
package thermal_throttle_pkg;

    // register byte addresses on the plain register port
    localparam logic [7:0] ADDR_MISC_ENABLES = 8'h00;
    localparam logic [7:0] ADDR_SECOND_MONITOR_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_IDENT_LEAF = 8'h08;
    localparam logic [7:0] ADDR_IDENT_FEATURES = 8'h0c;
    localparam logic [7:0] ADDR_IDENT_EXT_FEATURES = 8'h10;
    localparam logic [7:0] ADDR_THROTTLE_STATUS = 8'h14;

    // field positions
    localparam int MISC_CLK_MOD_EN_BIT = 3;
    localparam int MISC_FV_EN_BIT = 13;
    localparam int SMC_SELECT_BIT = 16;
    localparam int SMC_TARGET_MSB = 15;
    localparam int SMC_TARGET_LSB = 0;
    localparam int IDENT_CLK_MOD_FLAG_BIT = 29;
    localparam int IDENT_FV_FLAG_BIT = 8;
    localparam int STAT_ENGAGED_BIT = 0;
    localparam int STAT_CLK_MOD_BIT = 1;
    localparam int STAT_FV_BIT = 2;
    localparam int STAT_TRIP_BIT = 3;
    localparam int STAT_EARLY_GEN_BIT = 4;

    // reset values and writable masks
    localparam logic [31:0] MISC_RESET = 32'h0000_0000;
    localparam logic [31:0] MISC_WMASK = 32'h0000_2008;
    localparam logic [31:0] SMC_RESET = 32'h0000_0000;
    localparam logic [31:0] SMC_WMASK = 32'h0001_ffff;
    localparam logic [31:0] IDENT_LEAF_RESET = 32'h0000_0000;
    localparam logic [31:0] IDENT_LEAF_FEATURES = 32'h0000_0001;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // which mechanisms this part carries
    localparam logic CLK_MOD_SUPPORTED = 1'b1;
    localparam logic FV_SUPPORTED = 1'b1;

    // operating point loaded at reset; requested_op_point passes through while not throttled by the frequency-voltage path
    localparam logic [15:0] OP_POINT_RESET = 16'h0000;

    // minimum engage time
    localparam int CLK_FREQ_MHZ = 100;
    localparam int MIN_ENGAGE_US = 1000;
    localparam int MIN_ENGAGE_COUNT = MIN_ENGAGE_US * CLK_FREQ_MHZ;
    localparam int ENGAGE_CNT_W = 17;

    // clock-modulation pattern: fraction of each period the core is clocked
    localparam int DUTY_STEP_CYCLES = 16;
    localparam int DUTY_STEPS = 8;
    localparam int DUTY_ON_STEPS = 4;
    localparam int DUTY_CNT_W = 7;
    localparam logic [6:0] DUTY_LAST = 7'(DUTY_STEP_CYCLES * DUTY_STEPS - 1);
    localparam logic [6:0] DUTY_ON_CYCLES = 7'(DUTY_STEP_CYCLES * DUTY_ON_STEPS);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CLK_MOD = 3'b010,
        ST_FREQ_VOLT = 3'b100
    } throttle_state_t;

endpackage

// ==== verilog/throttle_duty_gen.sv ====
`timescale 1ns/1ps
module throttle_duty_gen
    import thermal_throttle_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_l,
    input wire logic run,
    output logic clk_allow
);
    logic [DUTY_CNT_W-1:0] phase_reg;
    logic [DUTY_CNT_W-1:0] phase_next;
    logic allow_next;

    // phase restarts whenever the pattern is not running
    assign phase_next = (!run || phase_reg == DUTY_LAST) ? '0 : phase_reg + 7'h01;
    // clock passes while the pattern is stopped, and while running only during the allowed part of the period
    assign allow_next = !run || (phase_next < DUTY_ON_CYCLES);

    always_ff @(posedge ref_clk or negedge rst_l) begin
        if (!rst_l) begin
            phase_reg <= '0;
            clk_allow <= 1'b1;
        end else begin
            phase_reg <= phase_next;
            clk_allow <= allow_next;
        end
    end
endmodule

// ==== verilog/thermal_throttle_control.sv ====
`timescale 1ns/1ps
// What this block does
// - catastrophic trip always halts execution until the next reset
// - second, lower sensor trip drives the automatic throttles
// - clock-modulating throttle gates core clock internally, no external stop pin
// - identification feature word bit 29 flags clock-modulating throttle support
// - misc enable bit 3 enables clock-modulating throttle; cleared at reset
// - frequency-voltage throttle lowers frequency and voltage instead of gating
// - frequency-voltage throttle uses the same second-sensor trip
// - extended feature word bit 8 flags frequency-voltage throttle support
// - early parts: select bit 16 plus misc bit 3 enable frequency-voltage
// - early parts: misc bit 3 without select enables clock modulation
// - later parts: misc bit 13 enables frequency-voltage throttle
// - frequency-voltage trigger moves to target point in control bits 15:0
// - shutdown detector invisible; throttle features reported under leaf one
// - duty cycle means fraction of time the clock drives the core
// - throttle stays engaged at least 1 ms, then until trip clears
module thermal_throttle_control
    import thermal_throttle_pkg::*;
#(
    parameter int unsigned MIN_ENGAGE_CYCLES = MIN_ENGAGE_COUNT
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic catastrophic_trip,
    input wire logic thermal_trip,
    input wire logic early_gen_strap,
    input wire logic [15:0] requested_op_point,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic core_clk_enable,
    output logic halt_execution,
    output logic [15:0] op_point_target,
    output logic freq_voltage_active,
    output logic clock_mod_active
);
    localparam logic [ENGAGE_CNT_W-1:0] ENGAGE_LOAD = ENGAGE_CNT_W'(MIN_ENGAGE_CYCLES - 1);

    // reset release
    logic rst_meta_reg;
    logic rst_l;

    // pin synchronisers
    logic cat_meta_reg;
    logic cat_sync_reg;
    logic trip_meta_reg;
    logic trip_sync_reg;
    logic strap_meta_reg;
    logic strap_sync_reg;

    // strap capture
    logic strap_taken_reg;
    logic early_gen_reg;

    // software registers
    logic [31:0] misc_feature_enables_reg;
    logic [31:0] second_monitor_control_reg;
    logic [31:0] ident_leaf_reg;

    // throttle control
    throttle_state_t state_reg;
    throttle_state_t state_next;
    logic [ENGAGE_CNT_W-1:0] engage_cnt_reg;
    logic [ENGAGE_CNT_W-1:0] engage_cnt_next;
    logic duty_allow;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_l <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_l <= rst_meta_reg;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_l) begin
        if (!rst_l) begin
            cat_meta_reg <= 1'b0;
            cat_sync_reg <= 1'b0;
            trip_meta_reg <= 1'b0;
            trip_sync_reg <= 1'b0;
            strap_meta_reg <= 1'b0;
            strap_sync_reg <= 1'b0;
        end else begin
            cat_meta_reg <= catastrophic_trip;
            cat_sync_reg <= cat_meta_reg;
            trip_meta_reg <= thermal_trip;
            trip_sync_reg <= trip_meta_reg;
            strap_meta_reg <= early_gen_strap;
            strap_sync_reg <= strap_meta_reg;
        end
    end

    // generation strap is caught once, after both synchroniser stages hold the pin
    logic strap_fill_reg;
    logic strap_ready_reg;

    always_ff @(posedge ref_clk or negedge rst_l) begin
        if (!rst_l) begin
            strap_fill_reg <= 1'b0;
            strap_ready_reg <= 1'b0;
            strap_taken_reg <= 1'b0;
            early_gen_reg <= 1'b0;
        end else begin
            strap_fill_reg <= 1'b1;
            strap_ready_reg <= strap_fill_reg;
            if (strap_ready_reg && !strap_taken_reg) begin
                strap_taken_reg <= 1'b1;
                early_gen_reg <= strap_sync_reg;
            end
        end
    end

    // catastrophic shutdown: sticky, only reset clears it, no register shows it
    always_ff @(posedge ref_clk or negedge rst_l) begin
        if (!rst_l) begin
            halt_execution <= 1'b0;
        end else if (cat_sync_reg) begin
            halt_execution <= 1'b1;
        end
    end

    // register decode
    logic hit_misc;
    logic hit_smc;
    logic hit_leaf;
    logic hit_feat;
    logic hit_ext;
    logic hit_stat;
    logic leaf_is_features;
    logic [31:0] misc_wr_value;
    logic [31:0] smc_wr_value;

    assign hit_misc = reg_addr == ADDR_MISC_ENABLES;
    assign hit_smc = reg_addr == ADDR_SECOND_MONITOR_CONTROL;
    assign hit_leaf = reg_addr == ADDR_IDENT_LEAF;
    assign hit_feat = reg_addr == ADDR_IDENT_FEATURES;
    assign hit_ext = reg_addr == ADDR_IDENT_EXT_FEATURES;
    assign hit_stat = reg_addr == ADDR_THROTTLE_STATUS;
    assign misc_wr_value = reg_wdata & MISC_WMASK;
    assign smc_wr_value = reg_wdata & SMC_WMASK;

    always_ff @(posedge ref_clk or negedge rst_l) begin
        if (!rst_l) begin
            misc_feature_enables_reg <= MISC_RESET;
            second_monitor_control_reg <= SMC_RESET;
            ident_leaf_reg <= IDENT_LEAF_RESET;
        end else if (reg_wr) begin
            if (hit_misc) begin
                misc_feature_enables_reg <= misc_wr_value;
            end
            if (hit_smc) begin
                second_monitor_control_reg <= smc_wr_value;
            end
            if (hit_leaf) begin
                ident_leaf_reg <= reg_wdata;
            end
        end
    end

    // feature words answer only under the feature leaf
    logic [31:0] feat_word;
    logic [31:0] ext_feat_word;
    logic [31:0] status_word;
    logic [31:0] rdata_next;

    assign leaf_is_features = ident_leaf_reg == IDENT_LEAF_FEATURES;
    assign feat_word = (32'(CLK_MOD_SUPPORTED) << IDENT_CLK_MOD_FLAG_BIT)
        & {32{leaf_is_features}};
    assign ext_feat_word = (32'(FV_SUPPORTED) << IDENT_FV_FLAG_BIT)
        & {32{leaf_is_features}};

    logic engaged;

    assign engaged = state_reg != ST_IDLE;
    assign status_word = (32'(engaged) << STAT_ENGAGED_BIT)
        | (32'(state_reg == ST_CLK_MOD) << STAT_CLK_MOD_BIT)
        | (32'(state_reg == ST_FREQ_VOLT) << STAT_FV_BIT)
        | (32'(trip_sync_reg) << STAT_TRIP_BIT)
        | (32'(early_gen_reg) << STAT_EARLY_GEN_BIT);

    assign rdata_next = !reg_rd ? READ_ZERO :
        hit_misc ? misc_feature_enables_reg :
        hit_smc ? second_monitor_control_reg :
        hit_leaf ? ident_leaf_reg :
        hit_feat ? feat_word :
        hit_ext ? ext_feat_word :
        hit_stat ? status_word : READ_ZERO;

    always_ff @(posedge ref_clk or negedge rst_l) begin
        if (!rst_l) begin
            reg_rdata <= READ_ZERO;
        end else begin
            reg_rdata <= rdata_next;
        end
    end

    // mode selection by generation
    logic misc_clk_mod_bit;
    logic misc_fv_bit;
    logic select_bit;
    logic [15:0] target_point;
    logic fv_enabled;
    logic clk_mod_enabled;

    assign misc_clk_mod_bit = misc_feature_enables_reg[MISC_CLK_MOD_EN_BIT];
    assign misc_fv_bit = misc_feature_enables_reg[MISC_FV_EN_BIT];
    assign select_bit = second_monitor_control_reg[SMC_SELECT_BIT];
    assign target_point = second_monitor_control_reg[SMC_TARGET_MSB:SMC_TARGET_LSB];

    // with both enables set on a later part, frequency-voltage takes priority
    assign fv_enabled = FV_SUPPORTED && (early_gen_reg ?
        (misc_clk_mod_bit && select_bit) :
        misc_fv_bit);
    assign clk_mod_enabled = CLK_MOD_SUPPORTED && !fv_enabled && misc_clk_mod_bit
        && !(early_gen_reg && select_bit);

    // engage state machine
    logic hold_done;

    assign hold_done = engage_cnt_reg == '0;

    always_comb begin
        state_next = state_reg;
        engage_cnt_next = engage_cnt_reg;
        case (state_reg)
            ST_IDLE: begin
                engage_cnt_next = ENGAGE_LOAD;
                if (trip_sync_reg && fv_enabled) begin
                    state_next = ST_FREQ_VOLT;
                end else if (trip_sync_reg && clk_mod_enabled) begin
                    state_next = ST_CLK_MOD;
                end else begin
                    state_next = ST_IDLE;
                end
            end
            ST_CLK_MOD, ST_FREQ_VOLT: begin
                if (!hold_done) begin
                    engage_cnt_next = engage_cnt_reg - 1'b1;
                end else if (!trip_sync_reg) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
                engage_cnt_next = ENGAGE_LOAD;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_l) begin
        if (!rst_l) begin
            state_reg <= ST_IDLE;
            engage_cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            engage_cnt_reg <= engage_cnt_next;
        end
    end

    // internal stop-clock pattern while clock modulation is engaged
    logic duty_run;

    assign duty_run = state_reg == ST_CLK_MOD;

    throttle_duty_gen duty_gen (
        .ref_clk(ref_clk),
        .rst_l(rst_l),
        .run(duty_run),
        .clk_allow(duty_allow)
    );

    logic clk_enable_next;
    logic [15:0] op_point_next;

    assign clk_enable_next = !halt_execution && duty_allow;
    assign op_point_next = (state_reg == ST_FREQ_VOLT) ? target_point
        : requested_op_point;

    always_ff @(posedge ref_clk or negedge rst_l) begin
        if (!rst_l) begin
            core_clk_enable <= 1'b1;
            op_point_target <= OP_POINT_RESET;
            freq_voltage_active <= 1'b0;
            clock_mod_active <= 1'b0;
        end else begin
            core_clk_enable <= clk_enable_next;
            op_point_target <= op_point_next;
            freq_voltage_active <= state_reg == ST_FREQ_VOLT;
            clock_mod_active <= state_reg == ST_CLK_MOD;
        end
    end
endmodule

// ==== tb/thermal_throttle_control_assertions.sv ====
`timescale 1ns/1ps
module thermal_throttle_control_assertions #(
    parameter int unsigned MIN_ENGAGE_CYCLES = 20
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic catastrophic_trip,
    input wire logic thermal_trip,
    input wire logic [15:0] requested_op_point,
    input wire logic core_clk_enable,
    input wire logic halt_execution,
    input wire logic [15:0] op_point_target,
    input wire logic freq_voltage_active,
    input wire logic clock_mod_active
);
    logic [1:0] up_reg;
    logic [15:0] run_reg;
    wire logic engaged = freq_voltage_active | clock_mod_active;
    wire logic up = up_reg == 2'h3;
    // up marks the end of the internal reset stretch; run_reg counts engaged cycles
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_reg <= 2'h0;
            run_reg <= 16'h0000;
        end else begin
            up_reg <= up ? up_reg : up_reg + 2'h1;
            run_reg <= engaged ? run_reg + 16'h0001 : 16'h0000;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_gated_run;
        !core_clk_enable [*8];
    endsequence
    a_halt_sticky: assert property (halt_execution |=> halt_execution)
        else $error("halt dropped before reset");
    a_cat_halts: assert property (up && $rose(catastrophic_trip) |-> ##[1:4] halt_execution)
        else $error("no halt after shutdown trip");
    a_halt_gates: assert property (halt_execution |=> !core_clk_enable)
        else $error("core clocked while halted");
    a_fv_no_gating: assert property (
        freq_voltage_active && !halt_execution |-> core_clk_enable && !clock_mod_active)
        else $error("clock gated in frequency mode");
    a_op_passthru: assert property (
        up && !freq_voltage_active && !$past(freq_voltage_active)
        |-> op_point_target == $past(requested_op_point))
        else $error("operating point changed while not throttled");
    a_clk_free: assert property (
        up && !halt_execution && !clock_mod_active && !$past(clock_mod_active)
        |-> core_clk_enable)
        else $error("core clock gated while idle");
    a_min_engage: assert property ($fell(engaged) |-> run_reg >= MIN_ENGAGE_CYCLES - 1)
        else $error("throttle released too early");
    a_needs_trip: assert property ($rose(engaged) |-> $past(thermal_trip, 2))
        else $error("throttle engaged without trip");
    a_gate_block: assert property (
        clock_mod_active && $fell(core_clk_enable) |-> s_gated_run)
        else $error("stop interval too short");
endmodule

// ==== tb/thermal_sensor_model.sv ====
`timescale 1ns/1ps
module thermal_sensor_model #(
    parameter logic [7:0] TRIP_LEVEL = 8'h5a,
    parameter logic [7:0] SHUTDOWN_LEVEL = 8'h7d
) (
    input wire logic ref_clk,
    input wire logic [7:0] temp,
    output logic thermal_trip,
    output logic catastrophic_trip
);
    initial begin
        thermal_trip = 1'b0;
        catastrophic_trip = 1'b0;
    end
    // second sensor trips below the shutdown level and clears with hysteresis
    always @(posedge ref_clk) begin
        if (temp >= TRIP_LEVEL)
            thermal_trip <= 1'b1;
        else if (temp < TRIP_LEVEL - 8'h04)
            thermal_trip <= 1'b0;
        catastrophic_trip <= temp >= SHUTDOWN_LEVEL;
    end
endmodule

// ==== tb/thermal_throttle_control_tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin \
    samples_checked++; \
    if ((ac) !== (ex)) begin \
        num_errors++; \
        $display("Error %s expected %h seen %h", nm, ex, ac); \
    end \
end
module thermal_throttle_control_tb
    import thermal_throttle_pkg::*;
;
    localparam int unsigned MIN_CYC = 40;
    logic ref_clk, rst_n, early_gen_strap, reg_wr, reg_rd;
    logic catastrophic_trip, thermal_trip, core_clk_enable, halt_execution;
    logic freq_voltage_active, clock_mod_active;
    logic [15:0] requested_op_point, op_point_target;
    logic [7:0] reg_addr, temp;
    logic [31:0] reg_wdata, reg_rdata;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    thermal_throttle_control #(.MIN_ENGAGE_CYCLES(MIN_CYC)) dut (.ref_clk, .rst_n,
        .catastrophic_trip, .thermal_trip, .early_gen_strap, .requested_op_point, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .core_clk_enable, .halt_execution,
        .op_point_target, .freq_voltage_active, .clock_mod_active);
    thermal_sensor_model sensors (.ref_clk, .temp, .thermal_trip, .catastrophic_trip);
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    task automatic reset();
        @(posedge ref_clk);
        rst_n <= 1'b0;
        cyc(3);
        rst_n <= 1'b1;
        cyc(6);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(nm, ex, reg_rdata)
    endtask
    task automatic heat(input logic [7:0] t);
        @(posedge ref_clk);
        temp <= t;
        cyc(8);
        #1;
    endtask
    task automatic mode(input logic cm, input logic fv);
        #1;
        `CHK("clock_mod_active", cm, clock_mod_active)
        `CHK("freq_voltage_active", fv, freq_voltage_active)
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        {rst_n, early_gen_strap, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        temp = 8'h40;
        requested_op_point = 16'h1234;
        reset();
        rd(ADDR_MISC_ENABLES, MISC_RESET, "misc");
        rd(ADDR_SECOND_MONITOR_CONTROL, SMC_RESET, "control");
        rd(ADDR_IDENT_FEATURES, READ_ZERO, "features leaf0");
        wr(ADDR_IDENT_LEAF, IDENT_LEAF_FEATURES);
        rd(ADDR_IDENT_FEATURES, 32'h1 << IDENT_CLK_MOD_FLAG_BIT, "features");
        rd(ADDR_IDENT_EXT_FEATURES, 32'h1 << IDENT_FV_FLAG_BIT, "ext features");
        rd(8'h20, READ_ZERO, "unmapped");
        wr(ADDR_THROTTLE_STATUS, 32'hffff_ffff);
        rd(ADDR_THROTTLE_STATUS, READ_ZERO, "status");
        $display("test registers done");
        heat(8'h60);
        mode(1'b0, 1'b0);
        `CHK("core_clk_enable", 1'b1, core_clk_enable)
        `CHK("op_point_target", requested_op_point, op_point_target)
        heat(8'h40);
        $display("test disabled done");
        wr(ADDR_MISC_ENABLES, 32'h1 << MISC_CLK_MOD_EN_BIT);
        wr(ADDR_SECOND_MONITOR_CONTROL, 32'h0000_00a5);
        heat(8'h60);
        mode(1'b1, 1'b0);
        n = 0;
        repeat (DUTY_STEP_CYCLES * DUTY_STEPS) begin
            @(posedge ref_clk);
            #1;
            n += int'(core_clk_enable === 1'b0);
        end
        `CHK("stop cycles", (DUTY_STEPS - DUTY_ON_STEPS) * DUTY_STEP_CYCLES, n)
        heat(8'h40);
        mode(1'b0, 1'b0);
        $display("test clock modulation done");
        wr(ADDR_MISC_ENABLES, 32'h1 << MISC_FV_EN_BIT);
        requested_op_point <= 16'h4321;
        heat(8'h60);
        mode(1'b0, 1'b1);
        `CHK("op_point_target", 16'h00a5, op_point_target)
        `CHK("core_clk_enable", 1'b1, core_clk_enable)
        heat(8'h40);
        mode(1'b0, 1'b1);
        cyc(50);
        mode(1'b0, 1'b0);
        `CHK("op_point_target", 16'h4321, op_point_target)
        $display("test frequency mode done");
        early_gen_strap <= 1'b1;
        reset();
        wr(ADDR_MISC_ENABLES, 32'h1 << MISC_CLK_MOD_EN_BIT);
        wr(ADDR_SECOND_MONITOR_CONTROL, 32'h0001_005a);
        heat(8'h60);
        mode(1'b0, 1'b1);
        `CHK("op_point_target", 16'h005a, op_point_target)
        rd(ADDR_THROTTLE_STATUS, 32'h0000_001d, "status early fv");
        heat(8'h40);
        cyc(50);
        wr(ADDR_SECOND_MONITOR_CONTROL, 32'h0000_005a);
        heat(8'h60);
        mode(1'b1, 1'b0);
        heat(8'h40);
        cyc(50);
        $display("test early generation done");
        heat(8'h80);
        `CHK("halt_execution", 1'b1, halt_execution)
        `CHK("core_clk_enable", 1'b0, core_clk_enable)
        heat(8'h40);
        cyc(20);
        #1;
        `CHK("halt_execution", 1'b1, halt_execution)
        reset();
        #1;
        `CHK("halt_execution", 1'b0, halt_execution)
        $display("test shutdown done");
        conclude();
    end
endmodule
bind thermal_throttle_control thermal_throttle_control_assertions #(
    .MIN_ENGAGE_CYCLES(MIN_ENGAGE_CYCLES)
) checker_inst (.ref_clk, .rst_n, .catastrophic_trip, .thermal_trip, .requested_op_point,
    .core_clk_enable, .halt_execution, .op_point_target, .freq_voltage_active,
    .clock_mod_active);
